// file: rtl/cmo_pkg.sv
// Function
// - Stop sending and accepting MSUs on link
// - Keep sending status or fill units
// - New transfer point triggers transfer-prohibited
// - No alternative: block, discard, stop users
// - Local start sends order, remote sends ack
// - Every received order gets an ack
// - Changeover messages queue without priority
// - Message carries codes, link, signal, FSN
// - Purge retransmit buffer up to FSN
// - Then switch routing and forward buffers
// - Diverted traffic keeps order, no priority
// - Unknown FSN: emergency form, out-of-service
// - Emergency received: skip update, send new
// - Form chosen from local fault; an ack after completion is always emergency
// - No path: hold, then start traffic
// - Transfer-prohibited does not alter changeover
// - Retrieval impossible: new traffic, nothing else
// - No answer within timeout: new traffic
// - Implausible FSN: skip update, new traffic
// - Ack without sent order is ignored
// - Order after completion: emergency ack only
//
// Purpose: constants and types for the changeover controller
// Assumes: 125 MHz clock, 7-bit forward sequence numbers
// Notes: point codes 14 bits, link identity 4 bits
package cmo_pkg;

  localparam int CMO_CLK_MHZ = 125;
  localparam int CMO_MS_CYC = CMO_CLK_MHZ * 1000;
  localparam int CMO_MS_W = 17;
  localparam int CMO_TMR_W = 10;
  // Both hold and response times are provisional
  localparam logic [9:0] CMO_HOLD_MS = 10'h3e8;
  localparam logic [9:0] CMO_RESP_MS = 10'h3e8;
  localparam int CMO_FSN_W = 7;
  localparam int CMO_PC_W = 14;
  localparam int CMO_LINK_W = 4;

  typedef enum logic {
    CMO_ORDER,
    CMO_ACK
  } cmo_kind_t;

  typedef struct packed {
    logic [CMO_PC_W-1:0] dpc;
    logic [CMO_PC_W-1:0] opc;
    logic [CMO_LINK_W-1:0] link;
    cmo_kind_t kind;
    logic emerg;
    logic [CMO_FSN_W-1:0] fsn;
  } cmo_msg_t;

  typedef enum logic [2:0] {
    CMO_IDLE,
    CMO_WAIT,
    CMO_HOLD,
    CMO_UPD,
    CMO_RETR,
    CMO_DONE
  } cmo_state_t;

endpackage : cmo_pkg

// file: rtl/cmo_msdiv.sv
// Purpose: millisecond enable pulse from the system clock
// Assumes: CYC is at least 2
// Notes: tick is one cycle wide
`timescale 1ns/1ns
`default_nettype none
module cmo_msdiv
  import cmo_pkg::*;
#(
  parameter int unsigned CYC = CMO_MS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  output logic tick
);

  logic [CMO_MS_W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == CMO_MS_W'(CYC - 1));
      if (cnt_q == CMO_MS_W'(CYC - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : cmo_msdiv
`default_nettype wire

// file: rtl/cmo_mstmr.sv
// Purpose: millisecond timeout, counts while run is high
// Assumes: limit is at least 1
// Notes: expired pulses once; dropping run rearms it
`timescale 1ns/1ns
`default_nettype none
module cmo_mstmr
  import cmo_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  input wire logic [CMO_TMR_W-1:0] limit,
  output logic expired
);

  logic [CMO_TMR_W-1:0] cnt_q;
  logic fired_q;

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (tick && !fired_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == limit - 1'b1) begin
          fired_q <= 1'b1;
          expired <= 1'b1;
        end
      end
    end
  end

endmodule : cmo_mstmr
`default_nettype wire

// file: rtl/cmo_ctrl.sv
// Purpose: changeover control for one end of a signalling link
// Assumes: link conditions are levels valid at LINK_FAIL
// Notes: stays in completed state until LINK_RESTORE
`timescale 1ns/1ns
`default_nettype none
module cmo_ctrl
  import cmo_pkg::*;
#(
  parameter int unsigned MS_CYC = CMO_MS_CYC
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [CMO_LINK_W-1:0] LINK_ID,
  input wire logic [CMO_PC_W-1:0] OWN_PC,
  input wire logic [CMO_PC_W-1:0] PEER_PC,
  input wire logic LINK_FAIL,
  input wire logic LINK_RESTORE,
  input wire logic NO_TRAFFIC,
  input wire logic NO_ALT,
  input wire logic NEW_STP,
  input wire logic NO_PATH,
  input wire logic LOCAL_FAULT,
  input wire logic RETRIEVE_FAIL,
  input wire logic [CMO_FSN_W-1:0] LAST_RX_FSN,
  input wire logic [CMO_FSN_W-1:0] RTB_FIRST_FSN,
  input wire logic [CMO_FSN_W-1:0] RTB_LAST_FSN,
  input wire logic RX_VALID,
  input wire cmo_msg_t RX_MSG,
  input wire logic TX_READY,
  input wire logic RETRIEVE_DONE,
  output logic MSU_STOP,
  output logic FILL_SEND,
  output logic OOS_SEND,
  output logic TX_VALID,
  output cmo_msg_t TX_MSG,
  output logic PURGE,
  output logic [CMO_FSN_W-1:0] PURGE_FSN,
  output logic ROUTE_DIVERT,
  output logic RETRIEVE,
  output logic NEW_TRAFFIC,
  output logic TFP_START,
  output logic DEST_BLOCK,
  output logic DISCARD,
  output logic USER_STOP,
  output logic LINK_MGMT,
  output logic ACTIVE
);

  cmo_state_t st_q;
  logic ms_tick, hold_exp, resp_exp;
  logic fault_q, retr_fail_q, stp_q;
  logic ord_pend_q, ack_pend_q, ack_emerg_q;
  logic rx_ord, rx_ack, start, resolve, skip, go_upd, go_new, tx_free;

  // Message addressed to this end about this link
  function automatic logic rx_hit(input logic v, input cmo_msg_t m,
                                  input logic [CMO_LINK_W-1:0] id,
                                  input logic [CMO_PC_W-1:0] pc);
    rx_hit = v && (m.link == id) && (m.dpc == pc);
  endfunction : rx_hit
  // FSN must lie between the last acknowledged and last sent unit
  function automatic logic fsn_ok(input logic [CMO_FSN_W-1:0] f,
                                  input logic [CMO_FSN_W-1:0] first,
                                  input logic [CMO_FSN_W-1:0] last);
    logic [CMO_FSN_W-1:0] base;
    base = first - 1'b1;
    fsn_ok = (CMO_FSN_W'(f - base) <= CMO_FSN_W'(last - base));
  endfunction : fsn_ok

  cmo_msdiv #(.CYC(MS_CYC)) u_div (
    .clk(CLOCK), .srst(SRST), .tick(ms_tick)
  );
  cmo_mstmr u_no_path_hold_timer (
    .clk(CLOCK), .srst(SRST), .run(st_q == CMO_HOLD), .tick(ms_tick),
    .limit(CMO_HOLD_MS), .expired(hold_exp)
  );
  cmo_mstmr u_order_response_timer (
    .clk(CLOCK), .srst(SRST), .run(st_q == CMO_WAIT), .tick(ms_tick),
    .limit(CMO_RESP_MS), .expired(resp_exp)
  );

  always_comb begin
    rx_ord = rx_hit(RX_VALID, RX_MSG, LINK_ID, OWN_PC) &&
             (RX_MSG.kind == CMO_ORDER);
    rx_ack = rx_hit(RX_VALID, RX_MSG, LINK_ID, OWN_PC) &&
             (RX_MSG.kind == CMO_ACK);
    start = (st_q == CMO_IDLE) && (LINK_FAIL || rx_ord);
    // ack only counts after an order
    resolve = ((st_q == CMO_WAIT) && (rx_ord || rx_ack)) ||
              (start && rx_ord && !NO_TRAFFIC && !NO_ALT);
    skip = RX_MSG.emerg ||
           (start ? RETRIEVE_FAIL : retr_fail_q) ||
           !fsn_ok(RX_MSG.fsn, RTB_FIRST_FSN, RTB_LAST_FSN);
    go_upd = resolve && !skip;
    go_new = (resolve && skip) ||
             ((st_q == CMO_WAIT) && resp_exp) ||
             ((st_q == CMO_HOLD) && hold_exp);
    tx_free = !TX_VALID || TX_READY;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_q <= CMO_IDLE;
    end else begin
      unique case (st_q)
        CMO_IDLE: begin
          if (start) begin
            if (NO_TRAFFIC || NO_ALT) begin
              st_q <= CMO_DONE;
            end else if (go_upd) begin
              st_q <= CMO_UPD;
            end else if (go_new) begin
              st_q <= CMO_DONE;
            end else if (NO_PATH) begin
              st_q <= CMO_HOLD;
            end else begin
              st_q <= CMO_WAIT;
            end
          end
        end
        CMO_WAIT: begin
          if (go_upd) begin
            st_q <= CMO_UPD;
          end else if (go_new) begin
            st_q <= CMO_DONE;
          end
        end
        CMO_HOLD: begin
          if (go_new) begin
            st_q <= CMO_DONE;
          end
        end
        CMO_UPD: st_q <= CMO_RETR;
        CMO_RETR: begin
          if (RETRIEVE_DONE) begin
            st_q <= CMO_DONE;
          end
        end
        CMO_DONE: begin
          if (LINK_RESTORE) begin
            st_q <= CMO_IDLE;
          end
        end
      endcase
    end
  end

  // Conditions latched when changeover starts
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fault_q <= 1'b0;
      retr_fail_q <= 1'b0;
      stp_q <= 1'b0;
    end else if (start) begin
      fault_q <= LOCAL_FAULT;
      retr_fail_q <= RETRIEVE_FAIL;
      stp_q <= NEW_STP;
    end
  end

  // Pending order and ack requests; a new request wins over a load
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ord_pend_q <= 1'b0;
      ack_pend_q <= 1'b0;
      ack_emerg_q <= 1'b0;
    end else begin
      if (tx_free && ord_pend_q) begin
        ord_pend_q <= 1'b0;
      end else if (tx_free && ack_pend_q) begin
        ack_pend_q <= 1'b0;
      end
      if (start && !rx_ord && !NO_TRAFFIC && !NO_ALT && !NO_PATH) begin
        ord_pend_q <= 1'b1;
      end
      if (rx_ord) begin
        ack_pend_q <= 1'b1;
        ack_emerg_q <= LOCAL_FAULT || (st_q == CMO_DONE) ||
                       (st_q != CMO_IDLE && fault_q);
      end
    end
  end

  // held in the link queue until taken
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      TX_VALID <= 1'b0;
      TX_MSG <= '0;
    end else if (tx_free) begin
      TX_VALID <= ord_pend_q || ack_pend_q;
      TX_MSG.dpc <= PEER_PC;
      TX_MSG.opc <= OWN_PC;
      TX_MSG.link <= LINK_ID;
      TX_MSG.kind <= ord_pend_q ? CMO_ORDER : CMO_ACK;
      TX_MSG.emerg <= ord_pend_q ? fault_q : ack_emerg_q;
      TX_MSG.fsn <= (ord_pend_q ? fault_q : ack_emerg_q) ?
                    '0 : LAST_RX_FSN;
    end
  end

  // Link-side levels for the whole changeover
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      MSU_STOP <= 1'b0;
      FILL_SEND <= 1'b0;
      OOS_SEND <= 1'b0;
      ACTIVE <= 1'b0;
    end else if (start) begin
      MSU_STOP <= 1'b1;
      FILL_SEND <= 1'b1;
      OOS_SEND <= LOCAL_FAULT;
      ACTIVE <= 1'b1;
    end else if (st_q == CMO_DONE && LINK_RESTORE) begin
      MSU_STOP <= 1'b0;
      FILL_SEND <= 1'b0;
      OOS_SEND <= 1'b0;
      ACTIVE <= 1'b0;
    end
  end

  // Buffer update and diversion
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PURGE <= 1'b0;
      PURGE_FSN <= '0;
      RETRIEVE <= 1'b0;
      NEW_TRAFFIC <= 1'b0;
      ROUTE_DIVERT <= 1'b0;
      TFP_START <= 1'b0;
    end else begin
      PURGE <= go_upd;
      if (go_upd) begin
        PURGE_FSN <= RX_MSG.fsn;
      end
      RETRIEVE <= (st_q == CMO_UPD);
      NEW_TRAFFIC <= go_new;
      TFP_START <= ((st_q == CMO_UPD || go_new) &&
                    (start ? NEW_STP : stp_q)) ||
                   (start && NO_ALT && !NO_TRAFFIC);
      if (st_q == CMO_UPD || go_new) begin
        ROUTE_DIVERT <= 1'b1;
      end else if (st_q == CMO_DONE && LINK_RESTORE) begin
        ROUTE_DIVERT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DEST_BLOCK <= 1'b0;
      DISCARD <= 1'b0;
      USER_STOP <= 1'b0;
      LINK_MGMT <= 1'b0;
    end else begin
      LINK_MGMT <= start && NO_ALT && !NO_TRAFFIC;
      if (start && NO_ALT && !NO_TRAFFIC) begin
        DEST_BLOCK <= 1'b1;
        DISCARD <= 1'b1;
        USER_STOP <= 1'b1;
      end else if (st_q == CMO_DONE && LINK_RESTORE) begin
        DEST_BLOCK <= 1'b0;
        DISCARD <= 1'b0;
        USER_STOP <= 1'b0;
      end
    end
  end

  msu_stop_a: assert property (@(posedge CLOCK) disable iff (SRST)
    start |=> MSU_STOP && FILL_SEND) else $error("MSUs not stopped");
  fill_send_a: assert property (@(posedge CLOCK) disable iff (SRST)
    MSU_STOP |-> FILL_SEND) else $error("fill units missing");
  inacc_act_a: assert property (@(posedge CLOCK) disable iff (SRST)
    start && NO_ALT && !NO_TRAFFIC |=> DEST_BLOCK && USER_STOP &&
    LINK_MGMT && TFP_START && !ROUTE_DIVERT)
    else $error("inaccessible actions missing");
  tx_hold_a: assert property (@(posedge CLOCK) disable iff (SRST)
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_MSG))
    else $error("changeover message dropped");
  ord_ack_a: assert property (@(posedge CLOCK) disable iff (SRST)
    rx_ord |=> ##[0:3] TX_VALID && TX_MSG.kind == CMO_ACK)
    else $error("order not acknowledged");
  purge_seq_a: assert property (@(posedge CLOCK) disable iff (SRST)
    go_upd |=> PURGE && PURGE_FSN == $past(RX_MSG.fsn) ##1
    ROUTE_DIVERT && RETRIEVE) else $error("update sequence broken");
  emerg_skip_a: assert property (@(posedge CLOCK) disable iff (SRST)
    resolve && RX_MSG.emerg |=> NEW_TRAFFIC && !PURGE)
    else $error("emergency message updated buffer");
  oos_fault_a: assert property (@(posedge CLOCK) disable iff (SRST)
    start && LOCAL_FAULT |=> OOS_SEND) else $error("no out-of-service");
  resp_tmo_a: assert property (@(posedge CLOCK) disable iff (SRST)
    st_q == CMO_WAIT && resp_exp && !rx_ord && !rx_ack |=>
    NEW_TRAFFIC && st_q == CMO_DONE) else $error("timeout ignored");
  // stray ack ignored, idle or completed
  stray_ack_a: assert property (@(posedge CLOCK) disable iff (SRST)
    rx_ack && ((st_q == CMO_IDLE && !LINK_FAIL) ||
    (st_q == CMO_DONE && !LINK_RESTORE)) |=> $stable(st_q) && !PURGE &&
    !NEW_TRAFFIC) else $error("stray ack acted on");
  late_ord_a: assert property (@(posedge CLOCK) disable iff (SRST)
    st_q == CMO_DONE && rx_ord && !LINK_RESTORE |=> st_q == CMO_DONE &&
    ack_emerg_q) else $error("late order not answered in emergency");

  norm_cov_c: cover property (@(posedge CLOCK) disable iff (SRST)
    PURGE ##[1:20] st_q == CMO_DONE);
  tmo_cov_c: cover property (@(posedge CLOCK) disable iff (SRST)
    st_q == CMO_WAIT && resp_exp);
  hold_cov_c: cover property (@(posedge CLOCK) disable iff (SRST)
    st_q == CMO_HOLD && hold_exp);

endmodule : cmo_ctrl
`default_nettype wire

// file: verification/cmo_peer.sv
// Purpose: remote signalling point model facing the changeover controller
// Assumes: orders are answered dly+1 cycles after they are taken
// Notes: released receive lines toggle so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
module cmo_peer
  import cmo_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic answer,
  input wire logic fault,
  input wire logic [CMO_FSN_W-1:0] fsn,
  input wire logic [7:0] dly,
  input wire logic inj,
  input wire cmo_msg_t inj_msg,
  input wire logic tx_valid,
  input wire cmo_msg_t tx_msg,
  output logic tx_ready,
  output logic rx_valid,
  output cmo_msg_t rx_msg,
  output logic got,
  output cmo_msg_t got_msg
);
  logic pend_q;
  logic [7:0] cnt_q;
  cmo_msg_t ans_q;
  // A stalled queue makes the controller hold its message
  assign tx_ready = ~stall;
  always_ff @(posedge clk) begin
    got <= 1'b0;
    rx_valid <= 1'b0;
    rx_msg <= ~rx_msg;
    if (srst) begin
      pend_q <= 1'b0;
      rx_msg <= '0;
    end else begin
      if (tx_valid && tx_ready) begin
        got <= 1'b1;
        got_msg <= tx_msg;
        if (tx_msg.kind == CMO_ORDER && answer) begin
          pend_q <= 1'b1;
          cnt_q <= dly;
          ans_q <= '{tx_msg.opc, tx_msg.dpc, tx_msg.link, CMO_ACK, fault,
                     fault ? 7'h00 : fsn};
        end
      end
      if (pend_q) begin
        if (cnt_q == 8'h00) begin
          pend_q <= 1'b0;
          rx_valid <= 1'b1;
          rx_msg <= ans_q;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
      if (inj) begin
        rx_valid <= 1'b1;
        rx_msg <= inj_msg;
      end
    end
  end
endmodule : cmo_peer
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench for the changeover controller
// Assumes: millisecond divider shortened to 4 cycles
// Notes: every scenario starts from a fresh reset
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cmo_pkg::*;
;
  localparam int MS = 4;
  localparam int TMO = 1000 * MS;
  logic CLOCK, SRST, LINK_FAIL, LINK_RESTORE, NO_TRAFFIC, NO_ALT, NEW_STP;
  logic NO_PATH, LOCAL_FAULT, RETRIEVE_FAIL, RX_VALID, TX_READY;
  logic RETRIEVE_DONE, MSU_STOP, FILL_SEND, OOS_SEND, TX_VALID, PURGE;
  logic ROUTE_DIVERT, RETRIEVE, NEW_TRAFFIC, TFP_START, DEST_BLOCK, DISCARD;
  logic USER_STOP, LINK_MGMT, ACTIVE, stall, answer, fault, inj, got;
  logic [CMO_LINK_W-1:0] LINK_ID;
  logic [CMO_PC_W-1:0] OWN_PC, PEER_PC;
  logic [CMO_FSN_W-1:0] LAST_RX_FSN, RTB_FIRST_FSN, RTB_LAST_FSN;
  logic [CMO_FSN_W-1:0] PURGE_FSN, pfsn;
  cmo_msg_t RX_MSG, TX_MSG, inj_msg, got_msg, e;
  int fail_count, num_checks, purge_n, tx_n, tfp_n, mgmt_n, nt_n, n;
  wire [4:0] ev = {got, ROUTE_DIVERT, PURGE, NEW_TRAFFIC, ACTIVE};

  cmo_ctrl #(.MS_CYC(MS)) DUT (.CLOCK, .SRST, .LINK_ID, .OWN_PC, .PEER_PC,
    .LINK_FAIL, .LINK_RESTORE, .NO_TRAFFIC, .NO_ALT, .NEW_STP, .NO_PATH,
    .LOCAL_FAULT, .RETRIEVE_FAIL, .LAST_RX_FSN, .RTB_FIRST_FSN,
    .RTB_LAST_FSN, .RX_VALID, .RX_MSG, .TX_READY, .RETRIEVE_DONE,
    .MSU_STOP, .FILL_SEND, .OOS_SEND, .TX_VALID, .TX_MSG, .PURGE,
    .PURGE_FSN, .ROUTE_DIVERT, .RETRIEVE, .NEW_TRAFFIC, .TFP_START,
    .DEST_BLOCK, .DISCARD, .USER_STOP, .LINK_MGMT, .ACTIVE);
  cmo_peer u_peer (.clk(CLOCK), .srst(SRST), .stall, .answer, .fault,
    .fsn(pfsn), .dly(8'h03), .inj, .inj_msg, .tx_valid(TX_VALID),
    .tx_msg(TX_MSG), .tx_ready(TX_READY), .rx_valid(RX_VALID),
    .rx_msg(RX_MSG), .got, .got_msg);

  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // Pulses are counted one edge after they show
  always @(posedge CLOCK) begin
    if (PURGE === 1'b1) purge_n++;
    if (got === 1'b1) tx_n++;
    if (TFP_START === 1'b1) tfp_n++;
    if (LINK_MGMT === 1'b1) mgmt_n++;
    if (NEW_TRAFFIC === 1'b1) nt_n++;
  end

  task automatic chk(input string nm, input logic [63:0] x,
                     input logic [63:0] v);
    num_checks++;
    if (v !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, x, v);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask : tick
  task automatic wait_ev(input int idx, input int lim, output int w);
    w = 0;
    while (ev[idx] !== 1'b1 && w < lim) begin
      tick(1);
      w++;
    end
    chk($sformatf("event %0d", idx), 64'h1, {63'h0, ev[idx]});
  endtask : wait_ev
  task automatic rst();
    SRST = 1'b1;
    {LINK_FAIL, LINK_RESTORE, NO_TRAFFIC, NO_ALT, NEW_STP} = 5'h00;
    {NO_PATH, LOCAL_FAULT, RETRIEVE_FAIL, RETRIEVE_DONE} = 4'h0;
    {stall, fault, inj, answer} = 4'h1;
    pfsn = 7'h0f;
    tick(3);
    SRST = 1'b0;
    {purge_n, tx_n, tfp_n, mgmt_n, nt_n} = '0;
  endtask : rst
  task automatic fail_link();
    LINK_FAIL = 1'b1;
    tick(1);
    LINK_FAIL = 1'b0;
  endtask : fail_link
  task automatic send(input cmo_kind_t k, input logic em,
                      input logic [6:0] f);
    inj_msg = '{OWN_PC, PEER_PC, LINK_ID, k, em, f};
    inj = 1'b1;
    tick(1);
    inj = 1'b0;
  endtask : send

  task automatic t_normal();
    rst();
    NEW_STP = 1'b1;
    stall = 1'b1;
    fail_link();
    wait_ev(0, 3, n);
    chk("msu_stop", 1, MSU_STOP);
    chk("fill_send", 1, FILL_SEND);
    chk("oos_send", 0, OOS_SEND);
    tick(6);
    chk("tx_held", 1, TX_VALID);
    stall = 1'b0;
    wait_ev(4, 3, n);
    e = '{PEER_PC, OWN_PC, LINK_ID, CMO_ORDER, 1'b0, LAST_RX_FSN};
    chk("order", e, got_msg);
    wait_ev(2, 12, n);
    chk("purge_fsn", pfsn, PURGE_FSN);
    wait_ev(3, 3, n);
    chk("retrieve", 1, RETRIEVE);
    tick(1);
    chk("tfp", 1, tfp_n);
    RETRIEVE_DONE = 1'b1;
    tick(1);
    RETRIEVE_DONE = 1'b0;
    tick(2);
    send(CMO_ORDER, 1'b0, 7'h0c);
    wait_ev(4, 10, n);
    e = '{PEER_PC, OWN_PC, LINK_ID, CMO_ACK, 1'b1, 7'h00};
    chk("late_ack", e, got_msg);
    tick(4);
    chk("late_purge", 1, purge_n);
    $display("test normal done");
  endtask : t_normal

  task automatic t_remote();
    for (int i = 0; i < 2; i++) begin
      rst();
      LOCAL_FAULT = i[0];
      send(CMO_ORDER, ~i[0], pfsn);
      wait_ev(4, 10, n);
      e = '{PEER_PC, OWN_PC, LINK_ID, CMO_ACK, i[0],
            i[0] ? 7'h00 : LAST_RX_FSN};
      chk("ack", e, got_msg);
      chk("oos", i[0], OOS_SEND);
      tick(10);
      chk("one_msg", 1, tx_n);
    end
    $display("test remote done");
  endtask : t_remote

  task automatic t_skip();
    for (int m = 0; m < 3; m++) begin
      rst();
      fault = (m == 0);
      pfsn = (m == 1) ? 7'h64 : 7'h0f;
      RETRIEVE_FAIL = (m == 2);
      fail_link();
      wait_ev(1, 30, n);
      tick(2);
      chk("divert", 1, ROUTE_DIVERT);
      chk("no_purge", 0, purge_n);
    end
    $display("test skip done");
  endtask : t_skip

  task automatic t_timer();
    for (int m = 0; m < 2; m++) begin
      rst();
      NO_PATH = (m == 0);
      answer = 1'b0;
      fail_link();
      wait_ev(1, TMO + 50, n);
      chk("wait_len", 1, (n > TMO - 2 * MS) && (n < TMO + 2 * MS + 8));
      tick(2);
      chk("orders", m, tx_n);
    end
    $display("test timer done");
  endtask : t_timer

  task automatic t_quiet();
    rst();
    NO_ALT = 1'b1;
    fail_link();
    tick(6);
    chk("block", 3'h7, {DEST_BLOCK, DISCARD, USER_STOP});
    chk("tfp_mgmt", 2'h3, {tfp_n == 1, mgmt_n == 1});
    LINK_RESTORE = 1'b1;
    tick(1);
    LINK_RESTORE = 1'b0;
    tick(1);
    chk("restore", 4'h0, {ACTIVE, MSU_STOP, DEST_BLOCK, USER_STOP});
    rst();
    NO_TRAFFIC = 1'b1;
    fail_link();
    tick(8);
    chk("fill_only", 1, FILL_SEND);
    chk("no_action", 0, tx_n + nt_n + tfp_n);
    rst();
    send(CMO_ACK, 1'b0, pfsn);
    tick(6);
    chk("stray_ack", 0, ACTIVE + tx_n + purge_n);
    $display("test quiet done");
  endtask : t_quiet

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    LINK_ID = 4'h5;
    OWN_PC = 14'h0123;
    PEER_PC = 14'h0456;
    LAST_RX_FSN = 7'h2a;
    RTB_FIRST_FSN = 7'h0a;
    RTB_LAST_FSN = 7'h14;
    inj_msg = '0;
    rst();
    t_normal();
    t_remote();
    t_skip();
    t_timer();
    t_quiet();
    final_report();
  end
  // Two timeout runs dominate; this leaves ample margin
  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
